// File: bench/gpdr_pin_model.sv
// External pin model for one GPIO port.
// Assumes the bench sets ext_lvl, the level outside parties put on undriven pins.
`timescale 1ns/10ps
module gpdr_pin_model #(
  parameter int N = 5
) (
  // Device side
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  // Outside world
  input wire logic [N-1:0] ext_lvl,
  output logic [N-1:0] pin_in
);
  // Device wins where it drives, else the outside level
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the GPIO port data registers.
// Assumes gpdr_top with its AXI4-Lite slave and the pin model beside it.
`timescale 1ns/10ps
module tb_top;
  import gpdr_pkg::*;
  // ****
  // Signals
  // ****
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0] wstrb, wr_strb;
  logic [1:0] bresp, rresp, rs;
  logic [4:0] p0_in, p0_out, p0_oe, p0_ext;
  logic [1:0] p1_in, p1_out, p1_oe, p1_ext;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  gpdr_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .p0_pin_in(p0_in), .p0_pin_out(p0_out),
    .p0_pin_oe(p0_oe), .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe));
  gpdr_pin_model #(.N(P0_PINS)) u_pm0 (.pin_out(p0_out), .pin_oe(p0_oe),
    .ext_lvl(p0_ext), .pin_in(p0_in));
  gpdr_pin_model #(.N(P1_PINS)) u_pm1 (.pin_out(p1_out), .pin_oe(p1_oe),
    .ext_lvl(p1_ext), .pin_in(p1_in));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ****
  // Checking and closing
  // ****
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_resp(input logic [1:0] exp, input logic [1:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t resp exp=%h got=%h", $time, exp, got);
    end
  endtask

  task results;
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      results;
    end
  end

  // ****
  // Bus master tasks
  // ****
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= wr_strb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    p0_ext <= 5'h13;
    p1_ext <= 2'h2;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk_word(32'h00000000, {22'h0, p0_oe, p0_out});
    axi_read(PORT0_ADDR, rd, rs);
    chk_resp(RESP_OKAY, rs);
    chk_word(32'h00000013, rd);
    axi_read(PORT1_ADDR, rd, rs);
    chk_resp(RESP_OKAY, rs);
    chk_word(32'h00000002, rd);
  endtask

  task automatic t_p0_write;
    axi_write(PORT0_ADDR, 32'h0A150000, rs);
    chk_resp(RESP_OKAY, rs);
    @(negedge aclk);
    chk_word(32'h0000000A, {27'h0, p0_oe});
    chk_word(32'h00000015, {27'h0, p0_out});
    repeat (5) @(posedge aclk);
    axi_read(PORT0_ADDR, rd, rs);
    chk_word(32'h0A150011, rd);
  endtask

  task automatic t_p0_dir;
    axi_write(PORT0_ADDR, 32'h1F000000, rs);
    p0_ext <= 5'h0C;
    repeat (5) @(posedge aclk);
    axi_read(PORT0_ADDR, rd, rs);
    chk_word(32'h1F000000, rd);
    axi_write(PORT0_ADDR, 32'h001F0000, rs);
    @(negedge aclk);
    chk_word(32'h0000001F, {27'h0, p0_out});
    chk_word(32'h00000000, {27'h0, p0_oe});
    repeat (5) @(posedge aclk);
    axi_read(PORT0_ADDR, rd, rs);
    chk_word(32'h001F000C, rd);
  endtask

  task automatic t_p1;
    axi_write(PORT1_ADDR, 32'h03010000, rs);
    chk_resp(RESP_OKAY, rs);
    @(negedge aclk);
    chk_word(32'h00000019, {27'h0, p1_oe, 1'b0, p1_out});
    repeat (5) @(posedge aclk);
    axi_read(PORT1_ADDR, rd, rs);
    chk_word(32'h03010001, rd);
    axi_read(PORT0_ADDR, rd, rs);
    chk_word(32'h001F000C, rd);
    // Output byte lane only: direction must survive
    wr_strb = 4'h4;
    axi_write(PORT1_ADDR, 32'h00020000, rs);
    wr_strb = 4'hF;
    repeat (5) @(posedge aclk);
    axi_read(PORT1_ADDR, rd, rs);
    chk_word(32'h03020002, rd);
  endtask

  task automatic t_mid_reset;
    axi_write(PORT0_ADDR, 32'h1F150000, rs);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk_word(32'h00000000, {18'h0, p1_oe, p1_out, p0_oe, p0_out});
    repeat (6) @(posedge aclk);
    axi_read(PORT0_ADDR, rd, rs);
    chk_word(32'h0000000C, rd);
    axi_read(PORT1_ADDR, rd, rs);
    chk_word(32'h00000002, rd);
  endtask

  task automatic t_unmapped;
    axi_write(32'hFFFF0D24, 32'h1F1F0000, rs);
    chk_resp(RESP_SLVERR, rs);
    axi_read(32'hFFFF0D24, rd, rs);
    chk_resp(RESP_SLVERR, rs);
    chk_word(WORD_ZERO, rd);
    axi_read(PORT0_ADDR, rd, rs);
    chk_word(32'h001F000C, rd);
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, wdata, araddr} = {3{32'h00000000}};
    wstrb = 4'h0;
    wr_strb = 4'hF;
    p0_ext = 5'h00;
    p1_ext = 2'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_p0_write;
    t_p0_dir;
    t_p1;
    t_unmapped;
    t_mid_reset;
    results;
  end
endmodule

// File: logic/gpdr_pin_sync.sv
// Three-stage synchroniser with agreement filter for the port pin inputs.
// Assumes raw pins are asynchronous to aclk.
`timescale 1ns/10ps
module gpdr_pin_sync #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pin levels
  input wire logic [WIDTH-1:0] raw_in,
  // Filtered levels
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  // ****************************************
  // Sync chain
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
    end else begin
      stage1_ff <= raw_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // ****************************************
  // Agreement filter
  // ****************************************
  always_comb begin
    nxt_level = (~(stage2_ff ^ stage3_ff) & stage3_ff) | ((stage2_ff ^ stage3_ff) & level_ff);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_ff <= '0;
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

endmodule

// File: logic/gpdr_pkg.sv
// Constants and types shared by the GPIO port data register block.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package gpdr_pkg;

  // ****************************************
  // Bus and address map
  // ****************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam logic [ADDR_W-1:0] PORT0_ADDR = 32'hFFFF0D20;
  localparam logic [ADDR_W-1:0] PORT1_ADDR = 32'hFFFF0D30;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

  // ****************************************
  // Port layout
  // ****************************************
  localparam int PORTS = 2;
  localparam int PIN_MAX = 5;
  localparam int P0_PINS = 5;
  localparam int P1_PINS = 2;
  localparam int SYNC_W = P0_PINS + P1_PINS;
  localparam int DIR_LSB = 24;
  localparam int OUT_LSB = 16;
  localparam int IN_LSB = 0;
  localparam int DIR_BYTE = 3;
  localparam int OUT_BYTE = 2;
  localparam logic [PIN_MAX-1:0] P0_MASK = 5'h1F;
  localparam logic [PIN_MAX-1:0] P1_MASK = 5'h03;
  localparam logic [PIN_MAX-1:0] PIN_RST = 5'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [PIN_MAX-1:0] dir;
    logic [PIN_MAX-1:0] dout;
  } gpdr_port_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } gpdr_wreq_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0] resp;
  } gpdr_rresp_t;

  localparam gpdr_port_t PORT_RST = '{dir: PIN_RST, dout: PIN_RST};

endpackage

// File: logic/gpdr_top.sv
// GPIO port data registers for two ports behind an AXI4-Lite slave.
// Assumes pins are resolved outside from pin_out and pin_oe.
`timescale 1ns/10ps
module gpdr_top
  import gpdr_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port 0 pins
  input wire logic [P0_PINS-1:0] p0_pin_in,
  output logic [P0_PINS-1:0] p0_pin_out,
  output logic [P0_PINS-1:0] p0_pin_oe,
  // Port 1 pins
  input wire logic [P1_PINS-1:0] p1_pin_in,
  output logic [P1_PINS-1:0] p1_pin_out,
  output logic [P1_PINS-1:0] p1_pin_oe
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam logic [PIN_MAX-1:0] PORT_MASK [PORTS] = '{P0_MASK, P1_MASK};
  localparam logic [ADDR_W-1:0] PORT_ADDR [PORTS] = '{PORT0_ADDR, PORT1_ADDR};

  gpdr_port_t port_ff [PORTS];
  gpdr_wreq_t wreq_ff;
  gpdr_rresp_t rd_ff;
  gpdr_rresp_t nxt_rd;
  logic aw_got_ff;
  logic w_got_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic [PORTS-1:0] wr_hit;
  logic [PORTS-1:0] rd_hit;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_lvl;
  logic [PIN_MAX-1:0] lvl [PORTS];

  // ****************************************
  // Pin input synchroniser
  // ****************************************
  assign sync_raw = {p1_pin_in, p0_pin_in};

  gpdr_pin_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in(sync_raw),
    .level(sync_lvl)
  );

  assign lvl[0] = sync_lvl[P0_PINS-1:0];
  assign lvl[1] = {{(PIN_MAX-P1_PINS){1'b0}}, sync_lvl[SYNC_W-1:P0_PINS]};

  // ****************************************
  // Handshakes and decode
  // ****************************************
  assign s_axi_awready = !aw_got_ff;
  assign s_axi_wready = !w_got_ff;
  assign s_axi_arready = !rvalid_ff;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;

  for (genvar g = 0; g < PORTS; g++) begin : g_hit
    assign wr_hit[g] = (wreq_ff.addr == PORT_ADDR[g]);
    assign rd_hit[g] = (s_axi_araddr == PORT_ADDR[g]);
  end

  // ****************************************
  // Write address and data capture
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      wreq_ff.addr <= WORD_ZERO;
    end else if (aw_hs) begin
      aw_got_ff <= 1'b1;
      wreq_ff.addr <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      wreq_ff.data <= WORD_ZERO;
      wreq_ff.strb <= '0;
    end else if (w_hs) begin
      w_got_ff <= 1'b1;
      wreq_ff.data <= s_axi_wdata;
      wreq_ff.strb <= s_axi_wstrb;
    end else if (do_wr) begin
      w_got_ff <= 1'b0;
    end
  end

  // ****************************************
  // Write response
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (|wr_hit) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ****************************************
  // Port registers
  // ****************************************
  for (genvar g = 0; g < PORTS; g++) begin : g_port
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        port_ff[g] <= PORT_RST;
      end else if (do_wr && wr_hit[g]) begin
        // Only implemented pins keep state; reserved and level bits drop
        if (wreq_ff.strb[DIR_BYTE]) begin
          port_ff[g].dir <= wreq_ff.data[DIR_LSB +: PIN_MAX] & PORT_MASK[g];
        end
        if (wreq_ff.strb[OUT_BYTE]) begin
          port_ff[g].dout <= wreq_ff.data[OUT_LSB +: PIN_MAX] & PORT_MASK[g];
        end
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  assign p0_pin_out = port_ff[0].dout[P0_PINS-1:0];
  assign p0_pin_oe = port_ff[0].dir[P0_PINS-1:0];
  assign p1_pin_out = port_ff[1].dout[P1_PINS-1:0];
  assign p1_pin_oe = port_ff[1].dir[P1_PINS-1:0];

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    nxt_rd.data = WORD_ZERO;
    nxt_rd.resp = RESP_SLVERR;
    for (int p = 0; p < PORTS; p++) begin
      if (rd_hit[p]) begin
        nxt_rd.data[DIR_LSB +: PIN_MAX] = port_ff[p].dir;
        nxt_rd.data[OUT_LSB +: PIN_MAX] = port_ff[p].dout;
        nxt_rd.data[IN_LSB +: PIN_MAX] = lvl[p] & PORT_MASK[p];
        nxt_rd.resp = RESP_OKAY;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ff <= '{data: WORD_ZERO, resp: RESP_OKAY};
    end else if (ar_hs) begin
      rd_ff <= nxt_rd;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rd_ff.data;
  assign s_axi_rresp = rd_ff.resp;

  // ****************************************
  // Assertions
  // ****************************************
  chk_dir_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && wr_hit[0] && wreq_ff.strb[DIR_BYTE])
    |=> (p0_pin_oe == $past(wreq_ff.data[DIR_LSB +: P0_PINS])))
    else $error("port 0 direction did not follow write");

  chk_out_write: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && wr_hit[0] && wreq_ff.strb[OUT_BYTE])
    |=> (p0_pin_out == $past(wreq_ff.data[OUT_LSB +: P0_PINS])))
    else $error("port 0 output did not follow write");

  chk_level_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_hs && rd_hit[0])
    |=> (s_axi_rdata[IN_LSB +: P0_PINS] == $past(sync_lvl[P0_PINS-1:0])))
    else $error("port 0 level bits wrong on read");

  chk_port0_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_hs && s_axi_araddr == PORT0_ADDR)
    |=> (s_axi_rvalid && s_axi_rresp == RESP_OKAY))
    else $error("port 0 read not answered okay");

  chk_oe_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!do_wr) |=> ($stable(p0_pin_oe) && $stable(p0_pin_out) && $stable(p1_pin_oe)))
    else $error("pin drive changed without a write");

  chk_port1_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_hs && rd_hit[1])
    |=> (s_axi_rresp == RESP_OKAY
         && s_axi_rdata[DIR_LSB +: P1_PINS] == $past(p1_pin_oe)
         && s_axi_rdata[DIR_LSB+P1_PINS +: PIN_MAX-P1_PINS] == '0))
    else $error("port 1 read wrong");

  chk_reset_idle: assert property (
    @(posedge aclk)
    $rose(aresetn) |-> (p0_pin_oe == '0 && p1_pin_oe == '0 && p0_pin_out == '0
                        && !s_axi_bvalid && !s_axi_rvalid))
    else $error("state not cleared by reset");

  chk_readback: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_hs && rd_hit[0])
    |=> (s_axi_rdata[DIR_LSB +: P0_PINS] == $past(p0_pin_oe)
         && s_axi_rdata[OUT_LSB +: P0_PINS] == $past(p0_pin_out)))
    else $error("port 0 readback mismatch");

  chk_unmapped_err: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ar_hs && !(|rd_hit)) |=> (s_axi_rresp == RESP_SLVERR && s_axi_rdata == WORD_ZERO))
    else $error("unmapped read not refused");

  chk_bresp_due: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (aw_got_ff && w_got_ff && !bvalid_ff) |=> s_axi_bvalid)
    else $error("write response not raised");

  chk_bresp_port0: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && wr_hit[0]) |=> (s_axi_bvalid && s_axi_bresp == RESP_OKAY))
    else $error("port 0 write not answered okay");

  chk_bresp_port1: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && wr_hit[1]) |=> (s_axi_bvalid && s_axi_bresp == RESP_OKAY))
    else $error("port 1 write not answered okay");

  chk_bresp_unmapped: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (do_wr && !(|wr_hit)) |=> (s_axi_bvalid && s_axi_bresp == RESP_SLVERR))
    else $error("unmapped write not refused");

  cov_port0_write: cover property (
    @(posedge aclk) disable iff (!aresetn) do_wr && wr_hit[0]);

  cov_port1_read: cover property (
    @(posedge aclk) disable iff (!aresetn) ar_hs && rd_hit[1]);

  cov_unmapped: cover property (
    @(posedge aclk) disable iff (!aresetn) ar_hs && !(|rd_hit));

  cov_b_stall: cover property (
    @(posedge aclk) disable iff (!aresetn) s_axi_bvalid && !s_axi_bready ##1 s_axi_bready);

endmodule
